// >>> rtl/cms_defs.svh
// Purpose: Constants for the configuration mode sequencer
// Assumes: 20 MHz system clock, Wishbone register offsets in bytes
// Notes: Cycle counts derive from the clock rate below
// Contract
// - After power-on wait 100 ms if select pin low, 2 ms if high.
// - User I/O stays tri-stated through power-up, waiting and loading.
// - After loading, initialize: reset user registers, enable I/O, then run.
// - Loading plus initialization form command mode; running is user mode. Here cmd_state covers power-on, waiting and loading, not initialization.
// - Reload request in user mode reloads, reinitializes, then resumes user mode.
// - Weak pull-ups on during configuration unless the disable pin is high.
// - Boundary-scan loading fails beyond chain position 17.
// - Cascade: done hand-off leaves on enable out into next enable in.
// - Five load schemes: memory, serial, async parallel, fast parallel, scan.
// - Byte-wide load at 100 MHz finishes in under 100 ms.
// - Serial or parallel data; a processor may load through one location.
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH
`define CMS_CLK_HZ 20000000
`define CMS_POR_LONG_MS 100
`define CMS_POR_SHORT_MS 2
`define CMS_POR_LONG_CYC (`CMS_POR_LONG_MS * (`CMS_CLK_HZ / 1000))
`define CMS_POR_SHORT_CYC (`CMS_POR_SHORT_MS * (`CMS_CLK_HZ / 1000))
`define CMS_FAST_HZ 100000000
`define CMS_LOAD_MAX_MS 100
`define CMS_LOAD_MAX_BYTES (`CMS_LOAD_MAX_MS * (`CMS_FAST_HZ / 1000))
`define CMS_CFG_BITS 1024
`define CMS_INIT_CYC 8
`define CMS_MAX_CHAIN_POS 17
`define CMS_OFS_CTRL 8'h00
`define CMS_OFS_STATUS 8'h04
`define CMS_OFS_DATA 8'h08
`define CMS_OFS_CHAIN 8'h0c
`define CMS_CTRL_RELOAD 3
`define CMS_CHAIN_RESET 8'h01
`endif

// >>> rtl/cms_pkg.sv
// Purpose: Types for the configuration mode sequencer
// Assumes: Nothing beyond the defs header
// Notes: State codes appear in the status register
package cms_pkg;
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_WAIT = 3'h1,
    ST_LOAD = 3'h2,
    ST_INIT = 3'h3,
    ST_USER = 3'h4,
    ST_FAIL = 3'h5
  } cms_state_type;
  typedef enum logic [2:0] {
    SCH_MEMORY = 3'h0,
    SCH_PASSIVE_SERIAL = 3'h1,
    SCH_PASSIVE_PARALLEL_ASYNC = 3'h2,
    SCH_FAST_PARALLEL = 3'h3,
    SCH_BOUNDARY_SCAN = 3'h4
  } cms_scheme_type;
endpackage : cms_pkg

// >>> rtl/cms_sequencer.sv
// Purpose: Power-on, command mode and user mode sequencing with load schemes
// Assumes: Pins synchronous to clk_i, Wishbone classic slave, one-cycle ack
// Notes: Load data is counted, and only the last byte is kept for status; the fabric behind it is outside
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "cms_defs.svh"
module cms_sequencer
  import cms_pkg::*;
#(
  parameter int unsigned POR_LONG_CYCLES = `CMS_POR_LONG_CYC,
  parameter int unsigned POR_SHORT_CYCLES = `CMS_POR_SHORT_CYC,
  parameter int unsigned CFG_BITS = `CMS_CFG_BITS,
  parameter int unsigned INIT_CYCLES = `CMS_INIT_CYC,
  parameter int unsigned MAX_CHAIN_POS = `CMS_MAX_CHAIN_POS
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Straps and control pins
  input wire logic reset_delay_select_i,
  input wire logic weak_pullup_disable_i,
  input wire logic reload_request_n_i,
  input wire logic chain_load_enable_in_n_i,
  // Load data pins
  input wire logic cfg_strobe_i,
  input wire logic [7:0] cfg_data_i,
  // Device side
  output logic io_oe_o,
  output logic weak_pullup_en_o,
  output logic init_reset_o,
  output logic user_mode_o,
  output logic config_fail_o,
  output logic chain_load_enable_out_n_o
);
  localparam int CW = $clog2(POR_LONG_CYCLES + 1);
  localparam int LW = $clog2(CFG_BITS + 9);
  localparam int IW = $clog2(INIT_CYCLES + 1);

  initial
  begin
    if (POR_SHORT_CYCLES < 1 || POR_LONG_CYCLES < POR_SHORT_CYCLES)
      $error("Bad power-on delay counts");
    if (CFG_BITS < 8 || CFG_BITS % 8 != 0 || CFG_BITS / 8 >= `CMS_LOAD_MAX_BYTES)
      $error("Configuration size must be whole bytes and loadable in time");
    if (INIT_CYCLES < 1 || MAX_CHAIN_POS > 255)
      $error("Bad init length or chain limit");
  end

  function automatic logic scheme_serial(input logic [2:0] s);
    scheme_serial = (s == SCH_MEMORY) || (s == SCH_PASSIVE_SERIAL) ||
                    (s == SCH_BOUNDARY_SCAN);
  endfunction : scheme_serial

  function automatic logic cmd_state(input cms_state_type s);
    cmd_state = (s == ST_POR) || (s == ST_WAIT) || (s == ST_LOAD);
  endfunction : cmd_state

  cms_state_type state_reg, state_next;
  logic [CW-1:0] por_cnt_reg, por_len_reg;
  logic por_armed_reg, por_sel_reg;
  logic [LW-1:0] load_cnt_reg;
  logic [IW-1:0] init_cnt_reg;
  logic [2:0] scheme_reg;
  logic soft_reload_reg;
  logic [7:0] chain_pos_reg;
  logic [7:0] last_byte_reg;

  // Bus decode
  // Ack gates the hit so a strobe held across the answer is taken once
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wb_wr & (wb_adr_i == `CMS_OFS_CTRL);
  wire wr_data = wb_wr & (wb_adr_i == `CMS_OFS_DATA);
  wire wr_chain = wb_wr & (wb_adr_i == `CMS_OFS_CHAIN);

  // Load beats
  wire ppa_sel = (scheme_reg == SCH_PASSIVE_PARALLEL_ASYNC);
  wire beat = (state_reg == ST_LOAD) & (ppa_sel ? wr_data : cfg_strobe_i);
  wire [LW-1:0] beat_bits = scheme_serial(scheme_reg) ? LW'(1) : LW'(8);
  wire load_done = (load_cnt_reg >= LW'(CFG_BITS));
  wire beat_ready = (state_reg == ST_LOAD) & ppa_sel & ~load_done;
  wire reload_req = ~reload_request_n_i | soft_reload_reg;
  wire scan_bad = (scheme_reg == SCH_BOUNDARY_SCAN) &
                  (chain_pos_reg > 8'(MAX_CHAIN_POS));
  wire start_load = reload_request_n_i & ~soft_reload_reg &
                    ~chain_load_enable_in_n_i;
  wire por_end = por_armed_reg & (por_cnt_reg == '0);
  wire [CW-1:0] por_load = por_sel_reg ? CW'(POR_SHORT_CYCLES - 1) :
                           CW'(POR_LONG_CYCLES - 1);

  // Sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_POR: if (por_end) state_next = ST_WAIT;
      ST_WAIT: if (start_load) state_next = scan_bad ? ST_FAIL : ST_LOAD;
      ST_LOAD: if (load_done) state_next = ST_INIT;
      ST_INIT: if (init_cnt_reg == '0) state_next = ST_USER;
      ST_USER: state_next = ST_USER;
      ST_FAIL: state_next = ST_FAIL;
      default: state_next = ST_POR;
    endcase
    // Power-on delay always completes; reload is honoured everywhere after it
    if (reload_req && state_reg != ST_POR)
      state_next = ST_WAIT;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= ST_POR;
    else
      state_reg <= state_next;
  end

  // Strap is caught in the first cycle after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      por_armed_reg <= 1'b0;
      por_sel_reg <= 1'b0;
    end
    else if (!por_armed_reg)
    begin
      por_armed_reg <= 1'b1;
      por_sel_reg <= reset_delay_select_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !por_armed_reg)
      por_cnt_reg <= '1;
    else if (state_reg == ST_POR && por_cnt_reg == '1)
      por_cnt_reg <= por_load;
    else if (state_reg == ST_POR && por_cnt_reg != '0)
      por_cnt_reg <= por_cnt_reg - CW'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (state_reg != ST_LOAD)
      load_cnt_reg <= '0;
    else if (beat && !load_done)
      load_cnt_reg <= load_cnt_reg + beat_bits;
  end

  always_ff @(posedge clk_i)
  begin
    if (state_reg != ST_INIT)
      init_cnt_reg <= IW'(INIT_CYCLES - 1);
    else if (init_cnt_reg != '0)
      init_cnt_reg <= init_cnt_reg - IW'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      last_byte_reg <= 8'h00;
    else if (beat)
      last_byte_reg <= ppa_sel ? wb_dat_i[7:0] : cfg_data_i;
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scheme_reg <= SCH_MEMORY;
      soft_reload_reg <= 1'b0;
      chain_pos_reg <= `CMS_CHAIN_RESET;
    end
    else
    begin
      if (wr_ctrl)
        scheme_reg <= wb_dat_i[2:0];
      soft_reload_reg <= wr_ctrl & wb_dat_i[`CMS_CTRL_RELOAD];
      if (wr_chain)
        chain_pos_reg <= wb_dat_i[7:0];
    end
  end

  wire [31:0] rd_mux =
    (wb_adr_i == `CMS_OFS_CTRL) ? {29'h0, scheme_reg} :
    (wb_adr_i == `CMS_OFS_STATUS) ? {16'h0, last_byte_reg, 1'b0, beat_ready,
                                     user_mode_o, config_fail_o, 1'b0, state_reg} :
    (wb_adr_i == `CMS_OFS_CHAIN) ? {24'h0, chain_pos_reg} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_mux : 32'h0;
    end
  end

  // Pin outputs follow the next state so they line up with state_reg
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      io_oe_o <= 1'b0;
      weak_pullup_en_o <= 1'b0;
      init_reset_o <= 1'b0;
      user_mode_o <= 1'b0;
      config_fail_o <= 1'b0;
      chain_load_enable_out_n_o <= 1'b1;
    end
    else
    begin
      io_oe_o <= (state_next == ST_INIT) || (state_next == ST_USER);
      weak_pullup_en_o <= cmd_state(state_next) & ~weak_pullup_disable_i;
      init_reset_o <= (state_next == ST_INIT);
      user_mode_o <= (state_next == ST_USER);
      config_fail_o <= (state_next == ST_FAIL);
      chain_load_enable_out_n_o <= ~((state_next == ST_INIT) ||
                                     (state_next == ST_USER));
    end
  end

  // Helper counting cycles spent counting down the delay
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_reg != ST_POR || !por_armed_reg)
      por_len_reg <= '0;
    else if (por_len_reg != '1)
      por_len_reg <= por_len_reg + CW'(1);
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence leave_load;
    state_reg == ST_LOAD && load_done && !reload_req;
  endsequence
  sequence enter_init;
    state_reg == ST_INIT && init_reset_o && io_oe_o && !user_mode_o;
  endsequence

  por_delay_len_a: assert property (
    state_reg == ST_POR && state_next == ST_WAIT |->
      por_len_reg == (por_sel_reg ? CW'(POR_SHORT_CYCLES) : CW'(POR_LONG_CYCLES)))
    else $error("Power-on delay length wrong");
  io_hiz_cmd_a: assert property (
    cmd_state(state_reg) || state_reg == ST_FAIL |-> !io_oe_o)
    else $error("I/O enabled during command mode");
  load_init_seq_a: assert property (
    leave_load |=> enter_init)
    else $error("Initialization did not follow loading");
  user_excl_a: assert property (
    user_mode_o |-> !init_reset_o && io_oe_o && state_reg == ST_USER)
    else $error("User mode overlaps command mode");
  reload_user_a: assert property (
    state_reg == ST_USER && reload_req |=> state_reg == ST_WAIT && !user_mode_o)
    else $error("Reload request ignored");
  pullup_cfg_a: assert property (
    cmd_state(state_next) && !weak_pullup_disable_i |=> weak_pullup_en_o)
    else $error("Weak pull-up not enabled");
  scan_pos_fail_a: assert property (
    state_reg == ST_WAIT && start_load && scan_bad |=> state_reg == ST_FAIL ##0 config_fail_o)
    else $error("Scan load beyond chain limit not refused");
  chain_out_done_a: assert property (
    !chain_load_enable_out_n_o |-> state_reg == ST_INIT || state_reg == ST_USER)
    else $error("Enable out asserted before done");
  beat_width_a: assert property (
    beat && !load_done && !reload_req && !scheme_serial(scheme_reg) |=>
      load_cnt_reg == $past(load_cnt_reg) + LW'(8))
    else $error("Parallel beat not counted as a byte");
  user_after_init_a: assert property (
    state_reg == ST_USER && $past(state_reg) != ST_USER |-> $past(state_reg) == ST_INIT)
    else $error("User mode entered out of order");
  ack_one_cycle_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge held too long");
  fail_hold_a: assert property (
    state_reg == ST_FAIL && !reload_req |=> state_reg == ST_FAIL && config_fail_o)
    else $error("Failed load left without reload");
  por_hold_a: assert property (
    state_reg == ST_POR && !por_end |=> state_reg == ST_POR)
    else $error("Power-on delay cut short");
  wait_to_load_a: assert property (
    state_reg == ST_WAIT && start_load && !scan_bad |=> state_reg == ST_LOAD)
    else $error("Load did not start when enabled");
endmodule : cms_sequencer

// >>> test/cms_cfg_source.sv
// Purpose: Configuration data source standing in for a memory or host
// Assumes: Bench pulses go_i once the sequencer can take beats
// Notes: Idle data lines wander so a stale byte never looks valid
`timescale 1ns/1ns
module cms_cfg_source (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [7:0] beats_i,
  // Load data pins
  output logic strobe_o,
  output logic [7:0] data_o
);
  logic [7:0] left_reg;
  logic [7:0] wander_reg;
  logic gap_reg;
  assign strobe_o = (left_reg != 8'h00) && !gap_reg;
  assign data_o = strobe_o ? (left_reg ^ 8'ha5) : wander_reg;
  always_ff @(posedge clk_i)
  begin
    gap_reg <= slow_i && !gap_reg && !rst_i;
    wander_reg <= rst_i ? 8'h00 : wander_reg + 8'h3b;
    if (rst_i || go_i)
      left_reg <= rst_i ? 8'h00 : beats_i;
    else if (strobe_o)
      left_reg <= left_reg - 8'h01;
  end
endmodule : cms_cfg_source

// >>> test/config_mode_sequencer_tb.sv
// Purpose: Self-checking bench for the configuration mode sequencer
// Assumes: Power-on delays cut to 50 and 10 cycles, 32 config bits
// Notes: Pin monitors run all the time; scenarios check the rest
`timescale 1ns/1ns
`include "cms_defs.svh"
module config_mode_sequencer_tb
  import cms_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic psel = 1'b0;
  logic pud = 1'b0;
  logic rld_n = 1'b1;
  logic en_n = 1'b1;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [7:0] beats = 8'h04;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [7:0] cdat;
  logic [3:0] pins;
  logic ack, stb, oe, pu, ini, usr, fl, ceo_n;
  int fails = 0;
  int check_count = 0;
  int init_cnt = 0;
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  cms_sequencer #(.POR_LONG_CYCLES(50), .POR_SHORT_CYCLES(10), .CFG_BITS(32)) cms_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .reset_delay_select_i(psel), .weak_pullup_disable_i(pud), .reload_request_n_i(rld_n),
    .chain_load_enable_in_n_i(en_n), .cfg_strobe_i(stb), .cfg_data_i(cdat),
    .io_oe_o(oe), .weak_pullup_en_o(pu), .init_reset_o(ini), .user_mode_o(usr),
    .config_fail_o(fl), .chain_load_enable_out_n_o(ceo_n));
  cms_cfg_source cms_cfg_source_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .slow_i(slow), .beats_i(beats), .strobe_o(stb), .data_o(cdat));
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic lim(input int n, input int max);
    if (n >= max)
    begin
      fails++;
      $display("ERROR timeout");
      end_of_test();
    end
  endtask : lim
  // Pins snapshot at the falling edge, so checks never race the clock
  always @(negedge clk_i)
  begin
    pins <= {usr, fl, pu, oe};
    if (ini === 1'b1)
      chk("init pins", 2'b10, {oe, ceo_n});
    else if (usr !== 1'b1)
      chk("command pins", 2'b01, {oe, ceo_n});
  end
  always @(posedge clk_i)
    if (ini === 1'b1)
      init_cnt++;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    lim(n, 20);
    q = rdat;
    req <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wait_end();
    int n;
    for (n = 0; n < 400 && usr !== 1'b1 && fl !== 1'b1; n++)
      @(negedge clk_i);
    lim(n, 400);
    @(posedge clk_i);
  endtask : wait_end
  task automatic pulse_go(input logic s, input logic [7:0] b);
    slow <= s;
    beats <= b;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : pulse_go
  task automatic por(input logic s, input int lead);
    rst_i <= 1'b1;
    psel <= s;
    en_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (lead) @(posedge clk_i);
    bus(1'b0, `CMS_OFS_STATUS, 32'h0);
    chk("por state", {29'h0, ST_POR}, q & 32'h7);
    repeat (12) @(posedge clk_i);
    bus(1'b0, `CMS_OFS_STATUS, 32'h0);
    chk("wait state", {29'h0, ST_WAIT}, q & 32'h7);
    chk("pullup on", 4'b0010, pins);
    bus(1'b0, `CMS_OFS_CHAIN, 32'h0);
    chk("chain reset", 32'h1, q);
  endtask : por
  task automatic load_fast();
    bus(1'b1, `CMS_OFS_CTRL, {29'h0, SCH_FAST_PARALLEL});
    init_cnt = 0;
    en_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    pulse_go(1'b1, 8'h04);
    wait_end();
    chk("init cycles", 32'h8, init_cnt);
    chk("user pins", 4'b1001, pins);
    bus(1'b0, `CMS_OFS_STATUS, 32'h0);
    chk("user status", 32'h0000a424, q);
  endtask : load_fast
  task automatic reload_async();
    pud <= 1'b1;
    rld_n <= 1'b0;
    bus(1'b1, `CMS_OFS_CTRL, {29'h0, SCH_PASSIVE_PARALLEL_ASYNC});
    chk("reload pins", 4'b0000, pins);
    rld_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    bus(1'b0, `CMS_OFS_STATUS, 32'h0);
    chk("load ready", 32'h42, q & 32'h7f);
    for (int i = 1; i <= 4; i++)
      bus(1'b1, `CMS_OFS_DATA, 32'h60 | 32'(i));
    wait_end();
    bus(1'b0, `CMS_OFS_STATUS, 32'h0);
    chk("reload status", 32'h00006424, q);
    pud <= 1'b0;
  endtask : reload_async
  task automatic chain_scan();
    bus(1'b1, `CMS_OFS_CHAIN, 32'h12);
    bus(1'b1, `CMS_OFS_CTRL, {28'h0, 1'b1, SCH_BOUNDARY_SCAN});
    wait_end();
    chk("chain 18", 4'b0100, pins);
    bus(1'b1, `CMS_OFS_CHAIN, 32'h11);
    bus(1'b1, `CMS_OFS_CTRL, {28'h0, 1'b1, SCH_BOUNDARY_SCAN});
    pulse_go(1'b0, 8'h20);
    wait_end();
    chk("chain 17", 4'b1001, pins);
    bus(1'b0, `CMS_OFS_CTRL, 32'h0);
    chk("ctrl readback", {29'h0, SCH_BOUNDARY_SCAN}, q);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask : chain_scan
  initial
  begin
    por(1'b0, 40);
    por(1'b1, 0);
    load_fast();
    reload_async();
    chain_scan();
    end_of_test();
  end
endmodule : config_mode_sequencer_tb
